/* File: rtl/fsbc_pkg.sv */
package fsbc_pkg;

    localparam int ADDR_W = 26;
    localparam int DATA_W = 16;

    // Command words and unlock addresses.
    localparam logic [15:0] CMD_UNLOCK1 = 16'h00aa;
    localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
    localparam logic [15:0] CMD_BYPASS_ENTRY = 16'h0020;
    localparam logic [15:0] CMD_PROG_SETUP = 16'h00a0;
    localparam logic [15:0] CMD_SUSPEND = 16'h00b0;
    localparam logic [15:0] CMD_RESUME = 16'h0030;
    localparam logic [15:0] CMD_BYPASS_EXIT1 = 16'h0090;
    localparam logic [15:0] CMD_BYPASS_EXIT2 = 16'h0000;
    localparam logic [15:0] CMD_RESET = 16'h00f0;
    localparam logic [15:0] CMD_AUTOSEL = 16'h0090;
    localparam logic [ADDR_W-1:0] ADDR_UNLOCK1 = 26'h0000555;
    localparam logic [ADDR_W-1:0] ADDR_UNLOCK2 = 26'h00002aa;

    // Bus cycle timing in ns and us, converted to ref_clk cycles.
    localparam int CLK_PERIOD_NS = 25;
    localparam int WE_PULSE_NS = 50;
    localparam int WE_PULSE_CYC = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_ACCESS_NS = 125;
    localparam int RD_ACCESS_CYC = (RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SUSPEND_MAX_US = 15;
    localparam int SUSPEND_CYC = SUSPEND_MAX_US * 1000 / CLK_PERIOD_NS;
    localparam int ACCEL_MAX_USES = 10;
    localparam int TIMER_W = 16;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_BYPASS_ENTER = 4'h1,
        OP_BYPASS_PROG = 4'h2,
        OP_BYPASS_EXIT = 4'h3,
        OP_SUSPEND = 4'h4,
        OP_RESUME = 4'h5,
        OP_RESET3 = 4'h6,
        OP_READ = 4'h7,
        OP_AUTOSEL = 4'h8,
        OP_ACCEL_ON = 4'h9,
        OP_ACCEL_OFF = 4'ha
    } fsbc_op_e;

    typedef struct packed {
        fsbc_op_e op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fsbc_req_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dout;
        logic doutEn_n;
        logic weN;
        logic oeN;
        logic ceN;
    } fsbc_bus_s;

endpackage

/* File: rtl/fsbc_bus_cycle.sv */
`timescale 1ns/1ps
`default_nettype none
module fsbc_bus_cycle
    import fsbc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic start,
    input wire logic isWrite,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [DATA_W-1:0] pinDin,
    output logic busy,
    output logic done,
    output logic [DATA_W-1:0] rdata,
    output fsbc_bus_s bus
);
    typedef enum logic [1:0] {BC_IDLE = 2'b00, BC_ACT = 2'b01, BC_END = 2'b11} fsbc_bc_e;
    typedef struct packed {
        fsbc_bc_e st;
        logic [3:0] cnt;
        logic wr;
        logic [DATA_W-1:0] rd;
        logic [DATA_W-1:0] s1;
        logic [DATA_W-1:0] s2;
        logic [DATA_W-1:0] s3;
        fsbc_bus_s b;
    } fsbc_bc_s;

    fsbc_bc_s state_r;
    fsbc_bc_s state_nxt;

    always_comb begin
        state_nxt = state_r;
        state_nxt.s1 = pinDin;
        state_nxt.s2 = state_r.s1;
        state_nxt.s3 = state_r.s2;
        unique case (state_r.st)
            BC_IDLE: begin
                if (start) begin
                    state_nxt.st = BC_ACT;
                    state_nxt.wr = isWrite;
                    state_nxt.b.addr = addr;
                    state_nxt.b.dout = wdata;
                    state_nxt.b.doutEn_n = !isWrite;
                    state_nxt.b.ceN = 1'b0;
                    state_nxt.b.weN = !isWrite;
                    state_nxt.b.oeN = isWrite;
                    state_nxt.cnt = isWrite ? 4'(WE_PULSE_CYC) : 4'(RD_ACCESS_CYC);
                end
            end
            BC_ACT: begin
                if (state_r.cnt != 4'h0) begin
                    state_nxt.cnt = state_r.cnt - 4'h1;
                end else begin
                    // Read data is taken only when the two later sync stages agree.
                    if (!state_r.wr && state_r.s2 == state_r.s3) begin
                        state_nxt.rd = state_r.s3;
                    end
                    if (state_r.wr || state_r.s2 == state_r.s3) begin
                        state_nxt.st = BC_END;
                        state_nxt.b.weN = 1'b1;
                        state_nxt.b.oeN = 1'b1;
                        state_nxt.b.ceN = 1'b1;
                    end
                end
            end
            BC_END: begin
                state_nxt.st = BC_IDLE;
                state_nxt.b.doutEn_n = 1'b1;
            end
            default: state_nxt.st = BC_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_r <= '{st: BC_IDLE, cnt: 4'h0, wr: 1'b0, rd: '0, s1: '0, s2: '0, s3: '0,
                b: '{addr: '0, dout: '0, doutEn_n: 1'b1, weN: 1'b1, oeN: 1'b1, ceN: 1'b1}};
        end else if (clkEn) begin
            state_r <= state_nxt;
        end
    end

    assign busy = state_r.st != BC_IDLE;
    assign done = clkEn && state_r.st == BC_END;
    assign rdata = state_r.rd;
    assign bus = state_r.b;
endmodule // fsbc_bus_cycle
`default_nettype wire

/* File: rtl/fsbc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module fsbc_host
    import fsbc_pkg::*;
#(
    parameter int SUSPEND_WAIT = SUSPEND_CYC,
    parameter int SECTOR_W = 10,
    parameter int SECTOR_LSB = 16
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic reqValid,
    output logic reqReady,
    input wire fsbc_req_s req,
    output logic rspValid,
    output logic [DATA_W-1:0] rspData,
    output logic rspError,
    output logic bypassMode,
    output logic progSuspended,
    output logic toggleSeen,
    input wire logic [DATA_W-1:0] pinDin,
    output fsbc_bus_s pinBus,
    output logic protectAccelHigh
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_ISSUE = 3'b001,
        H_WAIT = 3'b011,
        H_NEXT = 3'b010,
        H_HOLD = 3'b110,
        H_DONE = 3'b111
    } fsbc_host_e;

    typedef struct packed {
        fsbc_host_e st;
        fsbc_req_s cur;
        logic [1:0] step;
        logic bypass;
        logic accel;
        logic susp;
        logic progBusy;
        logic autosel;
        logic [TIMER_W-1:0] timer;
        logic [DATA_W-1:0] lastRd;
        logic haveRd;
        logic toggle;
        logic err;
        logic [DATA_W-1:0] data;
    } fsbc_host_s;

    // One use counter per sector; requests are refused at the limit, so no count wraps.
    logic [3:0] useCnt [0:(1<<SECTOR_W)-1];
    logic [SECTOR_W-1:0] curSector;

    fsbc_host_s state_r;
    fsbc_host_s state_nxt;
    logic bcStart;
    logic bcWrite;
    logic [ADDR_W-1:0] bcAddr;
    logic [DATA_W-1:0] bcData;
    logic bcBusy;
    logic bcDone;
    logic [DATA_W-1:0] bcRdata;
    logic lastStep;
    logic bumpUse;

    function automatic logic allowedInBypass(input fsbc_op_e op);
        return op inside {OP_READ, OP_BYPASS_PROG, OP_RESET3, OP_BYPASS_EXIT, OP_ACCEL_OFF};
    endfunction

    assign curSector = state_r.cur.addr[SECTOR_LSB +: SECTOR_W];

    // Direction, address and data of the bus cycle for each step of the current sequence.
    always_comb begin
        bcWrite = 1'b1;
        bcAddr = state_r.cur.addr;
        bcData = state_r.cur.data;
        lastStep = 1'b1;
        unique case (state_r.cur.op)
            OP_BYPASS_ENTER, OP_AUTOSEL: begin
                lastStep = state_r.step == 2'd2;
                bcAddr = (state_r.step == 2'd1) ? ADDR_UNLOCK2 : ADDR_UNLOCK1;
                bcData = (state_r.step == 2'd0) ? CMD_UNLOCK1 :
                         (state_r.step == 2'd1) ? CMD_UNLOCK2 :
                         (state_r.cur.op == OP_AUTOSEL) ? CMD_AUTOSEL : CMD_BYPASS_ENTRY;
            end
            OP_RESET3: begin
                lastStep = state_r.step == 2'd2;
                bcAddr = (state_r.step == 2'd1) ? ADDR_UNLOCK2 : ADDR_UNLOCK1;
                bcData = (state_r.step == 2'd0) ? CMD_UNLOCK1 :
                         (state_r.step == 2'd1) ? CMD_UNLOCK2 : CMD_RESET;
            end
            OP_BYPASS_PROG: begin
                lastStep = state_r.step == 2'd1;
                if (state_r.step == 2'd0) begin
                    bcData = CMD_PROG_SETUP;
                end
            end
            OP_BYPASS_EXIT: begin
                lastStep = state_r.step == 2'd1;
                bcData = (state_r.step == 2'd0) ? CMD_BYPASS_EXIT1 : CMD_BYPASS_EXIT2;
            end
            OP_SUSPEND: bcData = CMD_SUSPEND;
            OP_RESUME: bcData = CMD_RESUME;
            OP_READ: bcWrite = 1'b0;
            default: lastStep = 1'b1;
        endcase
    end

    assign bcStart = clkEn && state_r.st == H_ISSUE;
    assign bumpUse = clkEn && state_r.st == H_ISSUE && state_r.cur.op == OP_BYPASS_PROG &&
                     state_r.accel && state_r.step == 2'd1;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r.st)
            H_IDLE: begin
                if (reqValid) begin
                    state_nxt.cur = req;
                    state_nxt.step = 2'd0;
                    state_nxt.err = 1'b0;
                    state_nxt.st = H_ISSUE;
                    if (state_r.bypass && !allowedInBypass(req.op)) begin
                        state_nxt.err = 1'b1;
                        state_nxt.st = H_DONE;
                    end else if (req.op == OP_SUSPEND && !state_r.progBusy) begin
                        state_nxt.st = H_DONE;
                    end else if (req.op == OP_RESUME && !state_r.susp) begin
                        state_nxt.st = H_DONE;
                    end else if (req.op == OP_BYPASS_PROG && state_r.accel &&
                                 useCnt[req.addr[SECTOR_LSB +: SECTOR_W]] >=
                                 4'(ACCEL_MAX_USES)) begin
                        state_nxt.err = 1'b1;
                        state_nxt.st = H_DONE;
                    end else if (req.op == OP_ACCEL_ON || req.op == OP_ACCEL_OFF) begin
                        // Caller unlocks sectors before asking for the high level.
                        state_nxt.accel = req.op == OP_ACCEL_ON;
                        state_nxt.bypass = req.op == OP_ACCEL_ON ? 1'b1 : 1'b0;
                        state_nxt.st = H_DONE;
                        if (req.op == OP_ACCEL_OFF && state_r.progBusy) begin
                            state_nxt.err = 1'b1;
                            state_nxt.accel = state_r.accel;
                            state_nxt.bypass = state_r.bypass;
                        end
                    end
                end
            end
            H_ISSUE: state_nxt.st = H_WAIT;
            H_WAIT: begin
                if (bcDone) begin
                    state_nxt.data = bcRdata;
                    state_nxt.st = lastStep ? H_DONE : H_ISSUE;
                    state_nxt.step = state_r.step + 2'd1;
                    unique case (state_r.cur.op)
                        OP_BYPASS_ENTER: if (lastStep) state_nxt.bypass = 1'b1;
                        OP_BYPASS_EXIT: if (lastStep) state_nxt.bypass = 1'b0;
                        OP_BYPASS_PROG: if (lastStep) begin
                            state_nxt.progBusy = 1'b1;
                            state_nxt.haveRd = 1'b0;
                        end
                        OP_SUSPEND: begin
                            state_nxt.st = H_HOLD;
                            state_nxt.timer = TIMER_W'(SUSPEND_WAIT);
                        end
                        OP_RESUME: begin
                            state_nxt.susp = 1'b0;
                            state_nxt.haveRd = 1'b0;
                        end
                        OP_AUTOSEL: if (lastStep) state_nxt.autosel = 1'b1;
                        OP_RESET3: begin
                            if (lastStep) state_nxt.autosel = 1'b0;
                            if (lastStep) state_nxt.progBusy = state_r.susp;
                        end
                        OP_READ: begin
                            // Bit 6 toggling across reads means the program still runs.
                            if (state_r.progBusy && !state_r.susp && state_r.haveRd) begin
                                state_nxt.toggle = bcRdata[6] != state_r.lastRd[6];
                                state_nxt.progBusy = bcRdata[6] != state_r.lastRd[6];
                            end
                            state_nxt.lastRd = bcRdata;
                            state_nxt.haveRd = 1'b1;
                        end
                        default: state_nxt.st = H_DONE;
                    endcase
                end
            end
            H_HOLD: begin
                if (state_r.timer != '0) begin
                    state_nxt.timer = state_r.timer - TIMER_W'(1);
                end else begin
                    state_nxt.susp = 1'b1;
                    state_nxt.st = H_DONE;
                end
            end
            H_DONE: state_nxt.st = H_IDLE;
            default: state_nxt.st = H_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_r <= '{st: H_IDLE, cur: '{op: OP_NONE, addr: '0, data: '0}, step: 2'd0,
                bypass: 1'b0, accel: 1'b0, susp: 1'b0, progBusy: 1'b0, autosel: 1'b0,
                timer: '0, lastRd: '0, haveRd: 1'b0, toggle: 1'b0, err: 1'b0, data: '0};
        end else if (clkEn) begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            for (int i = 0; i < (1 << SECTOR_W); i++) begin
                useCnt[i] <= 4'h0;
            end
        end else if (bumpUse) begin
            useCnt[curSector] <= useCnt[curSector] + 4'h1;
        end
    end

    fsbc_bus_cycle u_cycle (
        .ref_clk(ref_clk),
        .reset(reset),
        .clkEn(clkEn),
        .start(bcStart),
        .isWrite(bcWrite),
        .addr(bcAddr),
        .wdata(bcData),
        .pinDin(pinDin),
        .busy(bcBusy),
        .done(bcDone),
        .rdata(bcRdata),
        .bus(pinBus)
    );

    // Reads during suspend rely on the caller choosing non-suspended sectors.
    assign reqReady = state_r.st == H_IDLE;
    assign rspValid = clkEn && state_r.st == H_DONE;
    assign rspData = state_r.data;
    assign rspError = state_r.err;
    assign bypassMode = state_r.bypass;
    assign progSuspended = state_r.susp;
    assign toggleSeen = state_r.toggle;
    assign protectAccelHigh = state_r.accel;
endmodule // fsbc_host
`default_nettype wire

/* File: tb/fsbc_host_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module fsbc_host_assertions
    import fsbc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire logic rspValid,
    input wire logic rspError,
    input wire logic bypassMode,
    input wire logic progSuspended,
    input wire fsbc_bus_s pinBus,
    input wire logic protectAccelHigh
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_rsp_one_cycle: assert property (rspValid |=> !rspValid)
        else $error("rspValid held longer than one cycle");
    a_reset_idle: assert property ($fell(reset) |-> pinBus.weN && pinBus.oeN && pinBus.ceN
        && pinBus.doutEn_n && !bypassMode && !progSuspended && reqReady)
        else $error("outputs not idle after reset");
    a_strobe_excl: assert property (!(!pinBus.weN && !pinBus.oeN))
        else $error("write and read strobes low together");
    a_write_drives: assert property (!pinBus.weN |-> !pinBus.ceN && !pinBus.doutEn_n)
        else $error("write strobe without select or data drive");
    a_read_releases: assert property (!pinBus.oeN |-> !pinBus.ceN && pinBus.doutEn_n)
        else $error("read with host driving data lines");
    a_we_width: assert property ($fell(pinBus.weN) |-> !pinBus.weN [*3] ##1 pinBus.weN)
        else $error("write strobe width wrong");
    a_write_stable: assert property (!pinBus.weN && !$past(pinBus.weN) |->
        $stable(pinBus.addr) && $stable(pinBus.dout))
        else $error("address or data moved during write strobe");
    a_take_busy: assert property (reqValid && reqReady && clkEn |=> !reqReady)
        else $error("ready stayed high after a request was taken");
    a_refuse_nobus: assert property (rspValid && rspError |-> pinBus.weN
        && $past(pinBus.weN) && $past(pinBus.weN, 2))
        else $error("refused request produced a write");
    a_accel_bypass: assert property ($rose(protectAccelHigh) |-> ##[0:8] bypassMode)
        else $error("bypass mode not entered with high level");
    a_rsp_bound: assert property (reqValid && reqReady && clkEn |-> ##[1:1000] rspValid)
        else $error("request never answered");

    c_bypass: cover property ($rose(bypassMode));
    c_suspend: cover property ($rose(progSuspended));
    c_refused: cover property (rspValid && rspError);
endmodule // fsbc_host_assertions

bind fsbc_host fsbc_host_assertions u_fsbc_host_assertions (.ref_clk(ref_clk), .reset(reset),
    .clkEn(clkEn), .reqValid(reqValid), .reqReady(reqReady), .rspValid(rspValid),
    .rspError(rspError), .bypassMode(bypassMode), .progSuspended(progSuspended),
    .pinBus(pinBus), .protectAccelHigh(protectAccelHigh));
`default_nettype wire

/* File: tb/fsbc_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fsbc_flash_model
    import fsbc_pkg::*;
#(
    parameter int PROG_READS = 3,
    parameter logic [15:0] ID_CODE = 16'h5a3c // Arbitrary identification value.
) (
    input wire logic ref_clk,
    input wire fsbc_bus_s pinBus,
    input wire logic accelHigh,
    output logic [DATA_W-1:0] pinDin
);
    logic bypass = 1'b0;
    logic susp = 1'b0;
    logic autoSel = 1'b0;
    logic setup = 1'b0;
    logic exitArm = 1'b0;
    logic tog = 1'b0;
    logic wasWr = 1'b0;
    logic wasRd = 1'b0;
    logic accPrev = 1'b0;
    int unlock = 0;
    int busyCnt = 0;
    logic [ADDR_W-1:0] wa = '0;
    logic [ADDR_W-1:0] memA = '0;
    logic [DATA_W-1:0] wd = '0;
    logic [DATA_W-1:0] memD = '0;
    logic [DATA_W-1:0] rd = '0;
    logic [DATA_W-1:0] last = '0;

    task automatic take_write();
        if (wd == CMD_SUSPEND) begin
            susp = susp || (busyCnt > 0);
        end else if (wd == CMD_RESUME && susp) begin
            susp = 1'b0;
        end else if (bypass && setup) begin
            memA = wa;
            memD = wd;
            busyCnt = PROG_READS;
            setup = 1'b0;
        end else if (bypass && exitArm) begin
            bypass = (wd != CMD_BYPASS_EXIT2);
            exitArm = 1'b0;
        end else if (unlock == 2) begin
            if (wd == CMD_RESET) autoSel = 1'b0;
            else if (!bypass && wd == CMD_BYPASS_ENTRY) bypass = 1'b1;
            else if (!bypass && wd == CMD_AUTOSEL) autoSel = 1'b1;
            unlock = 0;
        end else if (wd == CMD_UNLOCK1 && wa == ADDR_UNLOCK1) begin
            unlock = 1;
        end else if (wd == CMD_UNLOCK2 && wa == ADDR_UNLOCK2 && unlock == 1) begin
            unlock = 2;
        end else if (bypass && wd == CMD_PROG_SETUP) begin
            setup = 1'b1;
        end else if (bypass && wd == CMD_BYPASS_EXIT1) begin
            exitArm = 1'b1;
        end else begin
            unlock = 0;
        end
    endtask

    always @(posedge ref_clk) begin
        if (!pinBus.weN && !pinBus.ceN) begin
            wa = pinBus.addr;
            wd = pinBus.dout;
        end else if (wasWr) begin
            take_write();
        end
        if (!pinBus.oeN && !pinBus.ceN && !wasRd) begin
            if (busyCnt > 0 && !susp) begin
                tog = !tog;
                busyCnt--;
                rd <= {memD[15:7], tog, memD[5:0]};
            end else if (autoSel) begin
                rd <= ID_CODE;
            end else begin
                rd <= (pinBus.addr == memA) ? memD : 16'hffff;
            end
        end
        if (!pinBus.oeN && !pinBus.ceN) last = rd;
        if (accelHigh && !accPrev) bypass = 1'b1;
        if (!accelHigh && accPrev && busyCnt == 0) bypass = 1'b0;
        wasWr = !pinBus.weN && !pinBus.ceN;
        wasRd = !pinBus.oeN && !pinBus.ceN;
        accPrev = accelHigh;
    end

    // Released lines show the inverse of the last value, so a stale sample cannot match.
    always_comb pinDin = (!pinBus.oeN && !pinBus.ceN) ? rd : ~last;
endmodule // fsbc_flash_model
`default_nettype wire

/* File: tb/test_fsbc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module test_fsbc_host
    import fsbc_pkg::*;
;
    localparam int SW = 4;
    localparam logic [15:0] IDC = 16'h5a3c; // Arbitrary identification value.
    typedef struct packed {
        fsbc_op_e op;
        logic err;
        logic byp;
    } fsbc_row_s;

    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic clkEn = 1'b1;
    logic reqValid = 1'b0;
    fsbc_req_s req = '0;
    logic reqReady, rspValid, rspError, bypassMode, progSuspended, toggleSeen, accel;
    logic [DATA_W-1:0] rspData, pinDin;
    fsbc_bus_s pinBus;
    int fails = 0;
    int nCompared = 0;
    int lat = 0;
    fsbc_row_s rows [10] = '{'{OP_BYPASS_ENTER, 1'b0, 1'b1}, '{OP_AUTOSEL, 1'b1, 1'b1},
        '{OP_SUSPEND, 1'b1, 1'b1}, '{OP_RESUME, 1'b1, 1'b1}, '{OP_RESET3, 1'b0, 1'b1},
        '{OP_BYPASS_EXIT, 1'b0, 1'b0}, '{OP_SUSPEND, 1'b0, 1'b0}, '{OP_RESUME, 1'b0, 1'b0},
        '{OP_ACCEL_ON, 1'b0, 1'b1}, '{OP_ACCEL_OFF, 1'b0, 1'b0}};

    always #12.5 ref_clk = ~ref_clk;

    fsbc_host #(.SUSPEND_WAIT(SW)) u_fsbc_host (.ref_clk(ref_clk), .reset(reset),
        .clkEn(clkEn), .reqValid(reqValid), .reqReady(reqReady), .req(req),
        .rspValid(rspValid), .rspData(rspData), .rspError(rspError), .bypassMode(bypassMode),
        .progSuspended(progSuspended), .toggleSeen(toggleSeen), .pinDin(pinDin),
        .pinBus(pinBus), .protectAccelHigh(accel));
    fsbc_flash_model #(.PROG_READS(3), .ID_CODE(IDC)) u_fsbc_flash_model (.ref_clk(ref_clk),
        .pinBus(pinBus), .accelHigh(accel), .pinDin(pinDin));

    task automatic results();
        $display("compared %0d mismatches %0d", nCompared, fails);
        if (fails == 0 && nCompared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        nCompared++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chkBit(input string name, input logic exp, input logic got);
        chk(name, {15'h0, exp}, {15'h0, got});
    endtask

    // Called at a falling edge; holds the request until the edge that takes it.
    task automatic issue(input fsbc_op_e op, input logic [ADDR_W-1:0] a,
            input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        req = '{op, a, d};
        reqValid = 1'b1;
        while (reqReady !== 1'b1 && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        @(negedge ref_clk);
        reqValid = 1'b0;
        lat = 0;
        while (rspValid !== 1'b1 && lat < 2000) begin
            @(negedge ref_clk);
            lat++;
        end
        if (n >= 50 || lat >= 2000) begin
            fails++;
            results();
        end
    endtask

    // Polls until two reads in a row give the programmed word, so the toggle has stopped.
    task automatic poll(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int k;
        logic [DATA_W-1:0] prev;
        logic [DATA_W-1:0] cur;
        logic seen;
        k = 0;
        cur = ~d;
        seen = 1'b0;
        do begin
            prev = cur;
            issue(OP_READ, a, '0);
            cur = rspData;
            seen = seen | toggleSeen;
            k++;
        end while (!(cur === d && prev === d) && k < 12);
        chk("polledData", d, rspData);
        chkBit("toggleSeen", 1'b1, seen);
        chkBit("toggleStopped", 1'b0, toggleSeen);
    endtask

    initial begin
        repeat (16) @(posedge ref_clk);
        @(negedge ref_clk);
        reset = 1'b0;
        chkBit("reqReady", 1'b1, reqReady);
        foreach (rows[i]) begin
            issue(rows[i].op, ADDR_UNLOCK1, '0);
            @(negedge ref_clk);
            chkBit("rspError", rows[i].err, rspError);
            chkBit("bypassMode", rows[i].byp, bypassMode);
            chkBit("deviceBypass", rows[i].byp, u_fsbc_flash_model.bypass);
            chkBit("progSuspended", 1'b0, progSuspended);
        end
        issue(OP_BYPASS_ENTER, '0, '0);
        issue(OP_BYPASS_PROG, 26'h0012345, 16'hbeef);
        chkBit("progError", 1'b0, rspError);
        issue(OP_BYPASS_EXIT, '0, '0);
        issue(OP_SUSPEND, 26'h3ffffff, '0);
        chkBit("suspendWait", 1'b1, lat > SW + WE_PULSE_CYC);
        chkBit("progSuspended", 1'b1, progSuspended);
        chkBit("deviceSuspended", 1'b1, u_fsbc_flash_model.susp);
        issue(OP_READ, 26'h0200000, '0);
        chk("otherSector", 16'hffff, rspData);
        issue(OP_AUTOSEL, '0, '0);
        issue(OP_READ, 26'h0012345, '0);
        chk("idCode", IDC, rspData);
        issue(OP_RESET3, '0, '0);
        chkBit("progSuspended", 1'b1, progSuspended);
        issue(OP_RESUME, 26'h1555555, '0);
        chkBit("progSuspended", 1'b0, progSuspended);
        issue(OP_RESUME, '0, '0);
        chkBit("rspError", 1'b0, rspError);
        poll(26'h0012345, 16'hbeef);
        issue(OP_SUSPEND, '0, '0);
        chkBit("progSuspended", 1'b0, progSuspended);
        issue(OP_ACCEL_ON, '0, '0);
        for (int i = 0; i < 11; i++) begin
            issue(OP_BYPASS_PROG, ADDR_W'(32'h30000 + i), DATA_W'(32'h1000 + i));
            chkBit("accelLimit", i == 10, rspError);
            if (i < 10) poll(ADDR_W'(32'h30000 + i), DATA_W'(32'h1000 + i));
        end
        issue(OP_ACCEL_OFF, '0, '0);
        @(negedge ref_clk);
        chkBit("bypassMode", 1'b0, bypassMode);
        clkEn = 1'b0;
        req = '{OP_ACCEL_ON, '0, '0};
        reqValid = 1'b1;
        repeat (3) @(negedge ref_clk);
        chkBit("frozenAccel", 1'b0, accel);
        reqValid = 1'b0;
        clkEn = 1'b1;
        @(negedge ref_clk);
        issue(OP_BYPASS_ENTER, '0, '0);
        reset = 1'b1;
        repeat (2) @(negedge ref_clk);
        reset = 1'b0;
        chkBit("bypassMode", 1'b0, bypassMode);
        chkBit("reqReady", 1'b1, reqReady);
        results();
    end
endmodule // test_fsbc_host
`default_nettype wire
